// ---- include/pssd_map.vh ----
// Register offsets, field positions and reset values of the strap loader
`ifndef PSSD_MAP_VH
`define PSSD_MAP_VH

// Register byte addresses
`define PSSD_P1_FC_ADDR      12'h000
`define PSSD_P2_FC_ADDR      12'h004
`define PSSD_P2_BASIC_ADDR   12'h008
`define PSSD_P2_ADV_ADDR     12'h00c
`define PSSD_P2_XOVER_ADDR   12'h010
`define PSSD_P2_MODES_ADDR   12'h014
`define PSSD_P1_ADV_ADDR     12'h018
`define PSSD_STRAP_ADDR      12'h01c

// Manual flow-control registers (both ports)
`define PSSD_FC_RX_BIT       0
`define PSSD_FC_TX_BIT       1
`define PSSD_FC_BP_BIT       2
`define PSSD_FC_MANUAL_BIT   3
`define PSSD_FC_ACTRX_BIT    4
`define PSSD_FC_ACTTX_BIT    5

// Basic control register
`define PSSD_BC_DUPLEX_BIT   8
`define PSSD_BC_AN_BIT       12
`define PSSD_BC_SPEED_BIT    13

// Advertisement register
`define PSSD_ADV_10HD_BIT    5
`define PSSD_ADV_10FD_BIT    6
`define PSSD_ADV_100HD_BIT   7
`define PSSD_ADV_100FD_BIT   8
`define PSSD_ADV_PAUSE_BIT   10
`define PSSD_ADV_SEL_RST     5'h01

// Crossover control register
`define PSSD_XO_MDIX_BIT     13
`define PSSD_XO_AUTO_BIT     14
`define PSSD_XO_OVR_BIT      15
`define PSSD_XO_ACTAUTO_BIT  0
`define PSSD_XO_ACTMDIX_BIT  1

// Special modes register
`define PSSD_MODE_LSB        5
`define PSSD_MODE_W          3
`define PSSD_MODE_AN_ALL     3'h7

`endif

// ---- core/pssd_strap_loader.v ----
// Soft-strap default loader with APB access to the port control registers
//
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "pssd_map.vh"

// What this block does
// R1 - Port1 strap low: autoneg pause, advertise pause
// R2 - Port1 strap high: manual pause, no advertise
// R3 - Port2 auto crossover strap sets default
// R4 - Crossover override set ignores auto strap
// R5 - Manual crossover strap picks MDI or MDIX
// R6 - Port2 autoneg strap sets autoneg default
// R7 - Autoneg strap shapes speed, duplex, advert, mode
// R8 - Speed strap sets speed-select default
// R9 - Speed strap shapes advert bits and mode
// R10 - Duplex strap sets duplex-mode default
// R11 - Duplex strap shapes 10 full advert, mode
// R12 - Backpressure strap sets backpressure default
// R13 - Pause strap sets tx/rx; used manually only
// R14 - Pause strap gates pause detect/generate default
// R15 - Straps captured in reset; writes override
module pssd_strap_loader (
	input  wire        i_clk,
	input  wire        i_nrst,
	input  wire        i_p1_manual_pause_select_pin,
	input  wire        i_p2_auto_xover_pin,
	input  wire        i_p2_manual_mdix_pin,
	input  wire        i_p2_autoneg_pin,
	input  wire        i_p2_speed_pin,
	input  wire        i_p2_duplex_pin,
	input  wire        i_p2_backpressure_pin,
	input  wire        i_p2_pause_enable_pin,
	input  wire        i_p1_an_pause_tx,
	input  wire        i_p1_an_pause_rx,
	input  wire        i_p2_an_pause_tx,
	input  wire        i_p2_an_pause_rx,
	input  wire        i_psel,
	input  wire        i_penable,
	input  wire        i_pwrite,
	input  wire [11:0] i_paddr,
	input  wire [31:0] i_pwdata,
	output reg  [31:0] o_prdata,
	output reg         o_pready,
	output reg         o_pslverr,
	output reg         o_p1_tx_pause_active,
	output reg         o_p1_rx_pause_active,
	output reg         o_p2_tx_pause_active,
	output reg         o_p2_rx_pause_active,
	output reg         o_p2_backpressure_active,
	output reg         o_p2_auto_xover_active,
	output reg         o_p2_mdix_active
);

////////////////////////////////////////////////////////////////////////////////
// Strap capture

// Straps are sampled every cycle in reset; last value before release stays
reg  [7:0] strap_q;
wire [7:0] strap_d = {i_p2_pause_enable_pin, i_p2_backpressure_pin,
	i_p2_duplex_pin, i_p2_speed_pin, i_p2_autoneg_pin,
	i_p2_manual_mdix_pin, i_p2_auto_xover_pin,
	i_p1_manual_pause_select_pin};

always @(posedge i_clk) begin
	if (!i_nrst)
		strap_q <= strap_d; // R15
end

wire s_p1_man = strap_d[0];
wire s_amdix  = strap_d[1];
wire s_mmdix  = strap_d[2];
wire s_an     = strap_d[3];
wire s_speed  = strap_d[4];
wire s_duplex = strap_d[5];
wire s_bp     = strap_d[6];
wire s_pause  = strap_d[7];

////////////////////////////////////////////////////////////////////////////////
// Register state

reg        p1_manual_pause_select_bit_q;
reg        p1_tx_pause_enable_q;
reg        p1_rx_pause_enable_q;
reg        p2_manual_pause_reg_q;
reg        p2_tx_pause_enable_q;
reg        p2_rx_pause_enable_q;
reg        p2_backpressure_bit_q;
reg        negotiation_enable_bit_q;
reg        speed_select_low_bit_q;
reg        duplex_mode_bit_q;
reg  [3:0] p2_adv_abil_q;
reg        p2_adv_pause_q;
reg        p1_adv_pause_q;
reg        crossover_override_bit_q;
reg        xo_auto_q;
reg        xo_mdix_q;
reg  [2:0] p2_mode_q;

// Mode field: all-capable autoneg, else forced speed/duplex code
wire [2:0] mode_dflt = s_an ? `PSSD_MODE_AN_ALL :
	{1'b0, s_speed, s_duplex}; // R7 R9 R11

// Advertised abilities {100FD,100HD,10FD,10HD}
wire [3:0] adv_dflt;
assign adv_dflt[0] = s_an | ~s_speed;              // R7 R9
assign adv_dflt[1] = s_an | (~s_speed & s_duplex); // R7 R9 R11
assign adv_dflt[2] = s_an | s_speed;
assign adv_dflt[3] = s_an | (s_speed & s_duplex);

wire wr = i_psel & i_penable & i_pwrite & o_pready;
wire [31:0] d = i_pwdata;

// One strobe per writable register; a write to the strap register or an unmapped address hits none of them
wire wr_p1_fc  = wr & (i_paddr == `PSSD_P1_FC_ADDR);
wire wr_p2_fc  = wr & (i_paddr == `PSSD_P2_FC_ADDR);
wire wr_basic  = wr & (i_paddr == `PSSD_P2_BASIC_ADDR);
wire wr_p2_adv = wr & (i_paddr == `PSSD_P2_ADV_ADDR);
wire wr_p1_adv = wr & (i_paddr == `PSSD_P1_ADV_ADDR);
wire wr_xover  = wr & (i_paddr == `PSSD_P2_XOVER_ADDR);
wire wr_modes  = wr & (i_paddr == `PSSD_P2_MODES_ADDR);

// Port 1 flow control
always @(posedge i_clk) begin
	if (!i_nrst) begin
		p1_manual_pause_select_bit_q <= s_p1_man;
		p1_tx_pause_enable_q         <= 1'b0;
		p1_rx_pause_enable_q         <= 1'b0;
	end else if (wr_p1_fc) begin // R15
		p1_rx_pause_enable_q         <= d[`PSSD_FC_RX_BIT];
		p1_tx_pause_enable_q         <= d[`PSSD_FC_TX_BIT];
		p1_manual_pause_select_bit_q <= d[`PSSD_FC_MANUAL_BIT];
	end
end

// Port 1 pause advert follows the inverse of its manual strap
always @(posedge i_clk) begin
	if (!i_nrst)
		p1_adv_pause_q <= ~s_p1_man; // R1 R2
	else if (wr_p1_adv)
		p1_adv_pause_q <= d[`PSSD_ADV_PAUSE_BIT];
end

// Port 2 flow control
always @(posedge i_clk) begin
	if (!i_nrst) begin
		p2_manual_pause_reg_q <= 1'b0;
		p2_tx_pause_enable_q  <= s_pause; // R13 R14
		p2_rx_pause_enable_q  <= s_pause; // R13 R14
		p2_backpressure_bit_q <= s_bp; // R12
	end else if (wr_p2_fc) begin
		p2_rx_pause_enable_q  <= d[`PSSD_FC_RX_BIT];
		p2_tx_pause_enable_q  <= d[`PSSD_FC_TX_BIT];
		p2_backpressure_bit_q <= d[`PSSD_FC_BP_BIT];
		p2_manual_pause_reg_q <= d[`PSSD_FC_MANUAL_BIT];
	end
end

// Port 2 basic control
always @(posedge i_clk) begin
	if (!i_nrst) begin
		negotiation_enable_bit_q <= s_an; // R6
		speed_select_low_bit_q   <= s_an | s_speed; // R7 R8
		duplex_mode_bit_q        <= s_an | s_duplex; // R7 R10
	end else if (wr_basic) begin
		duplex_mode_bit_q        <= d[`PSSD_BC_DUPLEX_BIT];
		negotiation_enable_bit_q <= d[`PSSD_BC_AN_BIT];
		speed_select_low_bit_q   <= d[`PSSD_BC_SPEED_BIT];
	end
end

// Port 2 advertisement
always @(posedge i_clk) begin
	if (!i_nrst) begin
		p2_adv_abil_q  <= adv_dflt;
		p2_adv_pause_q <= 1'b1;
	end else if (wr_p2_adv) begin
		p2_adv_abil_q  <= d[`PSSD_ADV_100FD_BIT:`PSSD_ADV_10HD_BIT];
		p2_adv_pause_q <= d[`PSSD_ADV_PAUSE_BIT];
	end
end

// Port 2 crossover control
always @(posedge i_clk) begin
	if (!i_nrst) begin
		crossover_override_bit_q <= 1'b0;
		xo_auto_q                <= s_amdix; // R3
		xo_mdix_q                <= s_mmdix; // R5
	end else if (wr_xover) begin
		crossover_override_bit_q <= d[`PSSD_XO_OVR_BIT];
		xo_auto_q                <= d[`PSSD_XO_AUTO_BIT];
		xo_mdix_q                <= d[`PSSD_XO_MDIX_BIT];
	end
end

// Port 2 special modes
always @(posedge i_clk) begin
	if (!i_nrst)
		p2_mode_q <= mode_dflt;
	else if (wr_modes)
		p2_mode_q <= d[`PSSD_MODE_LSB+`PSSD_MODE_W-1:`PSSD_MODE_LSB];
end

// Port 2 manual-select default: the port 2 strap is outside this block
// so the select resets to autoneg resolution.

////////////////////////////////////////////////////////////////////////////////
// Resolved controls

// Override set: strap ignored, register fields rule crossover
wire xo_auto_src = crossover_override_bit_q ? xo_auto_q :
	strap_q[1]; // R3 R4
wire xo_mdix_src = crossover_override_bit_q ? xo_mdix_q :
	strap_q[2]; // R4 R5

// Pause lanes, order {p2 rx, p2 tx, p1 rx, p1 tx}
wire [3:0] lane_manual = {p2_manual_pause_reg_q, p2_manual_pause_reg_q,
	p1_manual_pause_select_bit_q, p1_manual_pause_select_bit_q};
wire [3:0] lane_reg    = {p2_rx_pause_enable_q, p2_tx_pause_enable_q,
	p1_rx_pause_enable_q, p1_tx_pause_enable_q};
wire [3:0] lane_an     = {i_p2_an_pause_rx, i_p2_an_pause_tx,
	i_p1_an_pause_rx, i_p1_an_pause_tx};
wire [3:0] lane_d;

// Both ports share the autoneg enable: only port 2 has one here
genvar g;
generate
	for (g = 0; g < 4; g = g + 1) begin : g_lane
		// Manual select hands the lane to its register bit
		assign lane_d[g] = lane_manual[g] ? lane_reg[g] :
			(negotiation_enable_bit_q & lane_an[g]); // R1 R2 R13
	end
endgenerate

wire p1_tx_d = lane_d[0];
wire p1_rx_d = lane_d[1];
wire p2_tx_d = lane_d[2];
wire p2_rx_d = lane_d[3];

always @(posedge i_clk) begin
	if (!i_nrst) begin
		o_p1_tx_pause_active     <= 1'b0;
		o_p1_rx_pause_active     <= 1'b0;
		o_p2_tx_pause_active     <= 1'b0;
		o_p2_rx_pause_active     <= 1'b0;
		o_p2_backpressure_active <= 1'b0;
		o_p2_auto_xover_active   <= 1'b0;
		o_p2_mdix_active         <= 1'b0;
	end else begin
		o_p1_tx_pause_active     <= p1_tx_d;
		o_p1_rx_pause_active     <= p1_rx_d;
		o_p2_tx_pause_active     <= p2_tx_d & duplex_mode_bit_q; // R14
		o_p2_rx_pause_active     <= p2_rx_d & duplex_mode_bit_q; // R14
		o_p2_backpressure_active <= p2_backpressure_bit_q &
			~duplex_mode_bit_q; // R12
		o_p2_auto_xover_active   <= xo_auto_src;
		o_p2_mdix_active         <= ~xo_auto_src & xo_mdix_src; // R5
	end
end

////////////////////////////////////////////////////////////////////////////////
// APB slave: one wait state, read data registered

reg [31:0] rd_d;
reg        hit;

always @* begin
	rd_d = 32'h0000_0000;
	hit  = 1'b1;
	case (i_paddr)
	`PSSD_P1_FC_ADDR: begin
		rd_d[`PSSD_FC_RX_BIT]     = p1_rx_pause_enable_q;
		rd_d[`PSSD_FC_TX_BIT]     = p1_tx_pause_enable_q;
		rd_d[`PSSD_FC_MANUAL_BIT] = p1_manual_pause_select_bit_q;
		rd_d[`PSSD_FC_ACTRX_BIT]  = o_p1_rx_pause_active;
		rd_d[`PSSD_FC_ACTTX_BIT]  = o_p1_tx_pause_active;
	end
	`PSSD_P2_FC_ADDR: begin
		rd_d[`PSSD_FC_RX_BIT]     = p2_rx_pause_enable_q;
		rd_d[`PSSD_FC_TX_BIT]     = p2_tx_pause_enable_q;
		rd_d[`PSSD_FC_BP_BIT]     = p2_backpressure_bit_q;
		rd_d[`PSSD_FC_MANUAL_BIT] = p2_manual_pause_reg_q;
		rd_d[`PSSD_FC_ACTRX_BIT]  = o_p2_rx_pause_active;
		rd_d[`PSSD_FC_ACTTX_BIT]  = o_p2_tx_pause_active;
	end
	`PSSD_P2_BASIC_ADDR: begin
		rd_d[`PSSD_BC_DUPLEX_BIT] = duplex_mode_bit_q;
		rd_d[`PSSD_BC_AN_BIT]     = negotiation_enable_bit_q;
		rd_d[`PSSD_BC_SPEED_BIT]  = speed_select_low_bit_q;
	end
	`PSSD_P2_ADV_ADDR: begin
		rd_d[4:0] = `PSSD_ADV_SEL_RST;
		rd_d[`PSSD_ADV_100FD_BIT:`PSSD_ADV_10HD_BIT] = p2_adv_abil_q;
		rd_d[`PSSD_ADV_PAUSE_BIT] = p2_adv_pause_q;
	end
	`PSSD_P1_ADV_ADDR: begin
		rd_d[4:0] = `PSSD_ADV_SEL_RST;
		rd_d[`PSSD_ADV_PAUSE_BIT] = p1_adv_pause_q;
	end
	`PSSD_P2_XOVER_ADDR: begin
		rd_d[`PSSD_XO_OVR_BIT]     = crossover_override_bit_q;
		rd_d[`PSSD_XO_AUTO_BIT]    = xo_auto_q;
		rd_d[`PSSD_XO_MDIX_BIT]    = xo_mdix_q;
		rd_d[`PSSD_XO_ACTAUTO_BIT] = o_p2_auto_xover_active;
		rd_d[`PSSD_XO_ACTMDIX_BIT] = o_p2_mdix_active;
	end
	`PSSD_P2_MODES_ADDR:
		rd_d[`PSSD_MODE_LSB+`PSSD_MODE_W-1:`PSSD_MODE_LSB] = p2_mode_q;
	`PSSD_STRAP_ADDR:
		rd_d[7:0] = strap_q;
	default:
		hit = 1'b0;
	endcase
end

always @(posedge i_clk) begin
	if (!i_nrst) begin
		o_pready  <= 1'b0;
		o_prdata  <= 32'h0000_0000;
		o_pslverr <= 1'b0;
	end else begin
		o_pready  <= i_psel & i_penable & ~o_pready;
		o_pslverr <= i_psel & i_penable & ~o_pready & ~hit;
		if (i_psel & i_penable & ~o_pready & ~i_pwrite)
			o_prdata <= rd_d;
	end
end

endmodule

// ---- sim/pssd_board.sv ----
// Board strap source model feeding the loader
`timescale 1ns/1ps
module pssd_board (
	input  wire [7:0] i_cfg,
	input  wire [3:0] i_an,
	output wire [7:0] o_pin,
	output wire [3:0] o_an
);
	// Straps are wired levels, never released
	assign o_pin = i_cfg;
	assign o_an  = i_an;
endmodule

// ---- sim/pssd_strap_loader_chk.sv ----
// Port checker for the strap loader
`timescale 1ns/1ps
module pssd_chk (
	input wire        i_clk,
	input wire        i_nrst,
	input wire        i_p1_manual_pause_select_pin,
	input wire        i_p2_auto_xover_pin,
	input wire        i_p2_manual_mdix_pin,
	input wire        i_p2_autoneg_pin,
	input wire        i_p2_duplex_pin,
	input wire        i_p2_backpressure_pin,
	input wire        i_p2_an_pause_tx,
	input wire        i_psel,
	input wire        i_penable,
	input wire [11:0] i_paddr,
	input wire        o_pready,
	input wire        o_pslverr,
	input wire        o_p1_tx_pause_active,
	input wire        o_p1_rx_pause_active,
	input wire        o_p2_tx_pause_active,
	input wire        o_p2_backpressure_active,
	input wire        o_p2_auto_xover_active,
	input wire        o_p2_mdix_active
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_nrst);
	sequence access_s;
		i_psel && i_penable && !o_pready;
	endsequence
	sequence release_s;
		$rose(i_nrst);
	endsequence
	////////////////////////////////////////////////////////////////////////
	reset_quiet_a: assert property (disable iff (1'b0)
		!i_nrst |=> !(o_pready || o_pslverr || o_p2_tx_pause_active
		|| o_p2_backpressure_active || o_p2_auto_xover_active))
		else $error("output active in reset");
	wait_state_a: assert property (access_s |=> o_pready)
		else $error("pready late");
	ready_pulse_a: assert property (o_pready |=> !o_pready)
		else $error("pready too long");
	unmapped_a: assert property (
		access_s ##0 i_paddr > 12'h01c |=> o_pslverr)
		else $error("unmapped not refused");
	xover_strap_a: assert property (release_s |=>
		o_p2_auto_xover_active == $past(i_p2_auto_xover_pin, 2))
		else $error("auto crossover default wrong");
	mdix_strap_a: assert property (
		release_s ##0 !$past(i_p2_auto_xover_pin) |=>
		o_p2_mdix_active == $past(i_p2_manual_mdix_pin, 2))
		else $error("mdix default wrong");
	bp_strap_a: assert property (release_s |=>
		o_p2_backpressure_active == ($past(i_p2_backpressure_pin, 2)
		&& !$past(i_p2_duplex_pin, 2) && !$past(i_p2_autoneg_pin, 2)))
		else $error("backpressure default wrong");
	pause_an_a: assert property (release_s |=>
		o_p2_tx_pause_active == ($past(i_p2_autoneg_pin, 2)
		&& $past(i_p2_an_pause_tx)))
		else $error("port2 pause default wrong");
	p1_manual_a: assert property (
		release_s ##0 $past(i_p1_manual_pause_select_pin) |=>
		!o_p1_tx_pause_active && !o_p1_rx_pause_active)
		else $error("port1 manual pause wrong");
endmodule
bind pssd_strap_loader pssd_chk u_pssd_chk (.*);

// ---- sim/port_soft_strap_defaults_test.sv ----
// Self-checking bench for the strap loader
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_fail++; \
	$display("mismatch t=%0t got %h exp %h", $time, a, b); end end
module port_soft_strap_defaults_test;
	reg         clk, nrst, psel, pen, pwr, err;
	reg  [11:0] pa;
	reg  [31:0] pwd, rd;
	reg  [63:0] e;
	reg  [7:0]  cfg;
	reg  [3:0]  an;
	reg  [12:0] rows [0:6];
	wire [7:0]  pin;
	wire [3:0]  ani;
	wire [31:0] prd;
	wire        prdy, perr;
	wire [6:0]  act;
	int         n_fail, checks_done;
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	pssd_board u_pssd_board (.i_cfg(cfg), .i_an(an), .o_pin(pin), .o_an(ani));
	pssd_strap_loader u_pssd_strap_loader (.i_clk(clk), .i_nrst(nrst),
		.i_p1_manual_pause_select_pin(pin[0]), .i_p2_auto_xover_pin(pin[1]),
		.i_p2_manual_mdix_pin(pin[2]), .i_p2_autoneg_pin(pin[3]),
		.i_p2_speed_pin(pin[4]), .i_p2_duplex_pin(pin[5]),
		.i_p2_backpressure_pin(pin[6]), .i_p2_pause_enable_pin(pin[7]),
		.i_p1_an_pause_tx(ani[3]), .i_p1_an_pause_rx(ani[2]),
		.i_p2_an_pause_tx(ani[1]), .i_p2_an_pause_rx(ani[0]),
		.i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa),
		.i_pwdata(pwd), .o_prdata(prd), .o_pready(prdy), .o_pslverr(perr),
		.o_p1_tx_pause_active(act[6]), .o_p1_rx_pause_active(act[5]),
		.o_p2_tx_pause_active(act[4]), .o_p2_rx_pause_active(act[3]),
		.o_p2_backpressure_active(act[2]), .o_p2_auto_xover_active(act[1]),
		.o_p2_mdix_active(act[0]));
	////////////////////////////////////////////////////////////////////////
	// Mask in the upper half, expected value in the lower
	function automatic [63:0] ex(input [7:0] s, input [11:0] a);
		case (a)
			12'h000: ex = {32'h8, 28'h0, s[0], 3'b0};
			12'h004: ex = {32'hf, 29'h0, s[6], s[7], s[7]};
			12'h008: ex = {32'h3100, 18'h0, s[3] | s[4], s[3], 3'b0,
				s[3] | s[5], 8'h0};
			12'h00c: ex = {32'h5ff, 21'h0, 1'b1, 1'b0,
				s[3] | (s[4] & s[5]), s[3] | s[4],
				s[3] | (~s[4] & s[5]), s[3] | ~s[4], 5'h01};
			12'h010: ex = {32'he003, 16'h0, 1'b0, s[1], s[2], 11'h0,
				~s[1] & s[2], s[1]};
			12'h014: ex = {32'he0, 24'h0, s[3] ? 3'h7 : {1'b0, s[4], s[5]},
				5'h0};
			12'h018: ex = {32'h400, 21'h0, ~s[0], 10'h0};
			default: ex = {32'hff, 24'h0, s};
		endcase
	endfunction
	task automatic apb(input w, input [11:0] a, input [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwr  <= w;
		pa   <= a;
		pwd  <= d;
		@(posedge clk);
		pen <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (prdy !== 1'b1 && n < 20);
		rd = prd;
		err = perr;
		psel <= 1'b0;
		pen  <= 1'b0;
		if (n >= 20)
			n_fail++;
	endtask
	task automatic rst(input [7:0] s);
		@(posedge clk);
		cfg  <= s;
		nrst <= 1'b0;
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		repeat (3) @(posedge clk);
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		final_report;
	end
	////////////////////////////////////////////////////////////////////////
	// Rows: straps, then {p2 tx, p2 rx, backpressure, auto, mdix}
	initial begin
		{nrst, psel, pen, pwr, pa, pwd, cfg} = '0;
		an = 4'b1110;
		n_fail = 0;
		checks_done = 0;
		rows = '{{8'h00, 5'h00}, {8'hff, 5'h12}, {8'h45, 5'h05},
			{8'h5c, 5'h11}, {8'ha2, 5'h02}, {8'h73, 5'h02}, {8'h50, 5'h04}};
		for (int i = 0; i < 7; i++) begin
			rst(rows[i][12:5]);
			`CHK(act[4:1], rows[i][4:1])
			`CHK(act[6:5], {2{~rows[i][5] & rows[i][8]}})
			if (!rows[i][6])
				`CHK(act[0], rows[i][0])
			for (int a = 0; a < 32; a += 4) begin
				apb(1'b0, a[11:0], 32'h0);
				e = ex(rows[i][12:5], a[11:0]);
				`CHK(rd & e[63:32], e[31:0])
			end
			$display("row %0d done", i);
		end
		// Override must win over a high auto strap
		rst(8'h06);
		`CHK(act[1], 1'b1)
		apb(1'b1, 12'h010, 32'h8000);
		apb(1'b0, 12'h010, 32'h0);
		`CHK(act[1:0], 2'b00)
		apb(1'b1, 12'h010, 32'ha000);
		apb(1'b0, 12'h010, 32'h0);
		`CHK({act[1:0], rd[15:0]}, 18'h1a002)
		$display("override test done");
		// Manual select hands pause to the tx/rx bits written with it
		rst(8'ha0);
		`CHK(act[4:3], 2'b00)
		apb(1'b1, 12'h004, 32'hb);
		apb(1'b0, 12'h004, 32'h0);
		`CHK({act[4:3], rd[5:0]}, 8'hfb)
		apb(1'b1, 12'h020, 32'hffffffff);
		apb(1'b0, 12'h020, 32'h0);
		`CHK({err, rd}, {1'b1, 32'h0})
		$display("manual and refusal test done");
		final_report;
	end
endmodule
